// ===== hw/uev_pkg.sv
// Package: register map, event bit positions and timing constants of the event status block
package uev_pkg;

  // ****************************************
  // Register byte addresses on the host port
  // ****************************************
  localparam logic [7:0] EVENT_FLAGS_OFF = 8'h18;
  localparam logic [7:0] CHIP_IDENTITY_OFF = 8'h70;
  localparam logic [7:0] RECEIVED_FRAME_NUMBER_OFF = 8'h74;

  // ****************************************
  // Event flag bit positions
  // ****************************************
  localparam int unsigned EP_FIRST_BIT = 12;
  localparam int unsigned EP_COUNT = 7;
  localparam int unsigned EP0_IN_BIT = 11;
  localparam int unsigned EP0_OUT_BIT = 10;
  localparam int unsigned RSVD_BIT = 9;
  localparam int unsigned SETUP_BIT = 8;
  localparam int unsigned VBUS_BIT = 7;
  localparam int unsigned DMA_BIT = 6;
  localparam int unsigned SPEED_BIT = 5;
  localparam int unsigned RESUME_BIT = 4;
  localparam int unsigned SUSPEND_BIT = 3;
  localparam int unsigned PSEUDO_BIT = 2;
  localparam int unsigned SOF_BIT = 1;
  localparam int unsigned BUS_RESET_BIT = 0;
  localparam logic [31:0] EVENT_IMPL_MASK = 32'h03ff_fdff;
  localparam logic [31:0] EVENT_FLAGS_RST = 32'h0000_0000;

  // ****************************************
  // Read-only field layouts and reset values
  // ****************************************
  localparam int unsigned FRAME_INDEX_W = 11;
  localparam int unsigned MICROFRAME_INDEX_W = 3;
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam int unsigned DMA_REASON_W = 16;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PSEUDO_FS_PERIOD_US = 1000;
  localparam int unsigned PSEUDO_HS_PERIOD_US = 125;
  localparam int unsigned SE0_OTG_MS = 2;
  localparam int unsigned PSEUDO_FS_CYC = (PSEUDO_FS_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned PSEUDO_HS_CYC = (PSEUDO_HS_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned SE0_OTG_CYC = (SE0_OTG_MS * 1000000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned TIMER_W = 19;

  // Frame register one-bit byte pointer for 8-bit reads
  typedef enum logic {
    UEV_BYTE_LOW = 1'b0,
    UEV_BYTE_HIGH = 1'b1
  } uev_byte_e;

endpackage

// ===== hw/uev_pseudo_tick.sv
// Free-running pseudo frame tick generator, period set by bus speed
`timescale 1ns/1ps
module uev_pseudo_tick #(
  parameter int unsigned FS_CYC = uev_pkg::PSEUDO_FS_CYC,
  parameter int unsigned HS_CYC = uev_pkg::PSEUDO_HS_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic high_speed_i,
  output logic tick_o
);

  logic [uev_pkg::TIMER_W-1:0] cnt_q;
  logic [uev_pkg::TIMER_W-1:0] last_d;

  // Not aligned to bus frame starts on purpose; a speed change takes effect at once on the running count
  always_comb begin
    last_d = high_speed_i ? uev_pkg::TIMER_W'(HS_CYC - 1) : uev_pkg::TIMER_W'(FS_CYC - 1);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (cnt_q >= last_d) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q >= last_d);
    end
  end

endmodule

// ===== hw/uev_event_status.sv
// Event flag, identity and frame number registers on the parallel host port
`timescale 1ns/1ps
module uev_event_status #(
  parameter int unsigned PSEUDO_FS_CYC = uev_pkg::PSEUDO_FS_CYC,
  parameter int unsigned PSEUDO_HS_CYC = uev_pkg::PSEUDO_HS_CYC,
  parameter int unsigned SE0_OTG_CYC = uev_pkg::SE0_OTG_CYC,
  parameter logic [15:0] CHIP_IDENTIFIER = 16'h5a5a, // Arbitrary value
  parameter logic [7:0] HW_VERSION = 8'h01 // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] hst_addr_i,
  input wire logic [15:0] hst_wdata_i,
  input wire logic hst_wr_i,
  input wire logic hst_rd_i,
  input wire logic hst_bus8_i,
  output logic [15:0] hst_rdata_o,
  output logic hst_rvalid_o,
  input wire logic [31:0] event_enable_i,
  output logic int_o,
  input wire logic [uev_pkg::EP_COUNT-1:0] endpoint_in_buffer_evt_i,
  input wire logic [uev_pkg::EP_COUNT-1:0] endpoint_out_buffer_evt_i,
  input wire logic ep0_in_evt_i,
  input wire logic ep0_out_evt_i,
  input wire logic setup_evt_i,
  input wire logic vbus_pin_i,
  input wire logic [uev_pkg::DMA_REASON_W-1:0] dma_reason_i,
  input wire logic high_speed_i,
  input wire logic suspended_i,
  input wire logic sof_evt_i,
  input wire logic [uev_pkg::FRAME_INDEX_W-1:0] frame_index_i,
  input wire logic [uev_pkg::MICROFRAME_INDEX_W-1:0] microframe_index_i,
  input wire logic bus_reset_i,
  input wire logic otg_en_i,
  input wire logic se0_i,
  output logic [31:0] event_flags_o,
  output logic [15:0] received_frame_number_o
);

  // ****************************************
  // Byte lane helpers
  // ****************************************
  function automatic logic [31:0] uev_lane_put(input logic [1:0] a, input logic [15:0] d, input logic b8);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (b8) begin
      r[a*8 +: 8] = d[7:0];
    end else begin
      r[a[1]*16 +: 16] = d;
    end
    return r;
  endfunction

  function automatic logic [15:0] uev_lane_get(input logic [1:0] a, input logic [31:0] w, input logic b8);
    logic [15:0] r;
    r = 16'h0000;
    if (b8) begin
      r[7:0] = w[a*8 +: 8];
    end else begin
      r = w[a[1]*16 +: 16];
    end
    return r;
  endfunction

  // ****************************************
  // Input conditioning
  // ****************************************
  logic vbus_s1_q;
  logic vbus_s2_q;
  logic vbus_d_q;
  logic hs_d_q;
  logic suspend_flag_d_q;
  logic [uev_pkg::DMA_REASON_W-1:0] dma_d_q;
  logic [uev_pkg::TIMER_W-1:0] se0_cnt_q;
  logic se0_evt_q;
  logic pseudo_tick;

  // Bus power comes straight from a pin
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vbus_s1_q <= 1'b0;
      vbus_s2_q <= 1'b0;
      vbus_d_q <= 1'b0;
    end else begin
      vbus_s1_q <= vbus_pin_i;
      vbus_s2_q <= vbus_s1_q;
      vbus_d_q <= vbus_s2_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hs_d_q <= 1'b0;
      suspend_flag_d_q <= 1'b0;
      dma_d_q <= '0;
    end else begin
      hs_d_q <= high_speed_i;
      suspend_flag_d_q <= suspended_i;
      dma_d_q <= dma_reason_i;
    end
  end

  // One event per unbroken SE0 stretch of SE0_OTG_CYC cycles or more; counter saturates so a long SE0 fires once
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      se0_cnt_q <= '0;
      se0_evt_q <= 1'b0;
    end else if (!(se0_i && otg_en_i)) begin
      se0_cnt_q <= '0;
      se0_evt_q <= 1'b0;
    end else if (se0_cnt_q != uev_pkg::TIMER_W'(SE0_OTG_CYC)) begin
      se0_cnt_q <= se0_cnt_q + 1'b1;
      se0_evt_q <= (se0_cnt_q == uev_pkg::TIMER_W'(SE0_OTG_CYC - 1));
    end else begin
      se0_evt_q <= 1'b0;
    end
  end

  uev_pseudo_tick #(
    .FS_CYC(PSEUDO_FS_CYC),
    .HS_CYC(PSEUDO_HS_CYC)
  ) u_pseudo_tick (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .high_speed_i(high_speed_i),
    .tick_o(pseudo_tick)
  );

  // ****************************************
  // Event flags
  // ****************************************
  logic [31:0] set_d;
  logic [31:0] clr_d;
  logic [31:0] flags_d;
  logic [31:0] flags_q;

  genvar g;
  generate
    for (g = 0; g < uev_pkg::EP_COUNT; g++) begin : g_ep
      assign set_d[uev_pkg::EP_FIRST_BIT + 2*g] = endpoint_out_buffer_evt_i[g];
      assign set_d[uev_pkg::EP_FIRST_BIT + 2*g + 1] = endpoint_in_buffer_evt_i[g];
    end
  endgenerate

  assign set_d[31:26] = 6'h00;
  assign set_d[uev_pkg::EP0_IN_BIT] = ep0_in_evt_i;
  assign set_d[uev_pkg::EP0_OUT_BIT] = ep0_out_evt_i;
  assign set_d[uev_pkg::RSVD_BIT] = 1'b0;
  assign set_d[uev_pkg::SETUP_BIT] = setup_evt_i;
  assign set_d[uev_pkg::VBUS_BIT] = vbus_s2_q & ~vbus_d_q;
  assign set_d[uev_pkg::DMA_BIT] = (dma_reason_i != dma_d_q);
  // A speed rise seen while suspended is a suspend artefact, not a new connection
  assign set_d[uev_pkg::SPEED_BIT] = high_speed_i & ~hs_d_q & ~suspended_i;
  assign set_d[uev_pkg::RESUME_BIT] = ~suspended_i & suspend_flag_d_q;
  assign set_d[uev_pkg::SUSPEND_BIT] = suspended_i & ~suspend_flag_d_q;
  assign set_d[uev_pkg::PSEUDO_BIT] = pseudo_tick;
  assign set_d[uev_pkg::SOF_BIT] = sof_evt_i;
  assign set_d[uev_pkg::BUS_RESET_BIT] = otg_en_i ? se0_evt_q : bus_reset_i;

  always_comb begin
    clr_d = 32'h0000_0000;
    if (hst_wr_i && (hst_addr_i[7:2] == uev_pkg::EVENT_FLAGS_OFF[7:2])) begin
      clr_d = uev_lane_put(hst_addr_i[1:0], hst_wdata_i, hst_bus8_i);
    end
    if (bus_reset_i) begin
      // A bus reset clears every flag; only a reset report set in the same cycle gets through
      flags_d = set_d & (32'h0000_0001 << uev_pkg::BUS_RESET_BIT);
    end else begin
      // A new event beats a clear in the same cycle
      flags_d = (flags_q & ~clr_d) | set_d;
    end
    flags_d = flags_d & uev_pkg::EVENT_IMPL_MASK;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_q <= uev_pkg::EVENT_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_o <= 1'b0;
      event_flags_o <= uev_pkg::EVENT_FLAGS_RST;
    end else begin
      int_o <= |(flags_q & event_enable_i);
      event_flags_o <= flags_d;
    end
  end

  // ****************************************
  // Frame number
  // ****************************************
  logic [15:0] frame_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_q <= uev_pkg::FRAME_RST;
    end else if (sof_evt_i) begin
      frame_q <= {2'b00, microframe_index_i, frame_index_i};
    end
  end

  assign received_frame_number_o = frame_q;

  // ****************************************
  // Host reads
  // ****************************************
  uev_pkg::uev_byte_e byte_q;
  logic [31:0] chip_word;
  logic frame_rd;

  assign chip_word = {8'h00, CHIP_IDENTIFIER, HW_VERSION};
  assign frame_rd = hst_rd_i && (hst_addr_i[7:2] == uev_pkg::RECEIVED_FRAME_NUMBER_OFF[7:2]);

  // Byte reads of the frame number alternate low then high; a 16-bit read restarts the pair
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_q <= uev_pkg::UEV_BYTE_LOW;
    end else if (frame_rd) begin
      case (byte_q)
        uev_pkg::UEV_BYTE_LOW: begin
          byte_q <= hst_bus8_i ? uev_pkg::UEV_BYTE_HIGH : uev_pkg::UEV_BYTE_LOW;
        end
        uev_pkg::UEV_BYTE_HIGH: begin
          byte_q <= uev_pkg::UEV_BYTE_LOW;
        end
        default: begin
          byte_q <= uev_pkg::UEV_BYTE_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hst_rdata_o <= 16'h0000;
      hst_rvalid_o <= 1'b0;
    end else begin
      hst_rvalid_o <= hst_rd_i;
      hst_rdata_o <= 16'h0000;
      if (hst_rd_i) begin
        if (hst_addr_i[7:2] == uev_pkg::EVENT_FLAGS_OFF[7:2]) begin
          hst_rdata_o <= uev_lane_get(hst_addr_i[1:0], flags_q, hst_bus8_i);
        end else if (hst_addr_i[7:2] == uev_pkg::CHIP_IDENTITY_OFF[7:2]) begin
          hst_rdata_o <= uev_lane_get(hst_addr_i[1:0], chip_word, hst_bus8_i);
        end else if (frame_rd) begin
          if (!hst_bus8_i) begin
            hst_rdata_o <= frame_q;
          end else if (byte_q == uev_pkg::UEV_BYTE_LOW) begin
            hst_rdata_o <= {8'h00, frame_q[7:0]};
          end else begin
            hst_rdata_o <= {8'h00, frame_q[15:8]};
          end
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_reserved_zero;
    flags_q[31:26] == 6'h00 && !flags_q[uev_pkg::RSVD_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set");

  property p_vbus_rise;
    $rose(vbus_s2_q) && !bus_reset_i |=> flags_q[uev_pkg::VBUS_BIT];
  endproperty
  a_vbus_rise: assert property (p_vbus_rise) else $error("bus power rise not flagged");

  property p_no_speed_in_suspend;
    suspended_i && !flags_q[uev_pkg::SPEED_BIT] |=> !flags_q[uev_pkg::SPEED_BIT];
  endproperty
  a_no_speed_in_suspend: assert property (p_no_speed_in_suspend) else $error("speed flag set in suspend");

  property p_suspend_resume;
    (suspended_i != suspend_flag_d_q) && !bus_reset_i
      |=> (flags_q[uev_pkg::SUSPEND_BIT] || !$past(suspended_i)) && (flags_q[uev_pkg::RESUME_BIT] || $past(suspended_i));
  endproperty
  a_suspend_resume: assert property (p_suspend_resume) else $error("suspend or resume not flagged");

  property p_sof_frame;
    sof_evt_i && !bus_reset_i |=> flags_q[uev_pkg::SOF_BIT] && frame_q[13:11] == $past(microframe_index_i) &&
      frame_q[10:0] == $past(frame_index_i);
  endproperty
  a_sof_frame: assert property (p_sof_frame) else $error("frame start not captured");

  property p_bus_reset;
    bus_reset_i |=> flags_q[31:1] == 31'h0000_0000 && flags_q[0] == ($past(otg_en_i) ? $past(se0_evt_q) : 1'b1);
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset flags wrong");

  property p_w1c;
    hst_wr_i && !hst_bus8_i && hst_addr_i == uev_pkg::EVENT_FLAGS_OFF && !bus_reset_i && set_d[15:0] == 16'h0000
      |=> (flags_q[15:0] & $past(hst_wdata_i)) == 16'h0000 && (flags_q[15:0] & ~$past(hst_wdata_i)) ==
          ($past(flags_q[15:0]) & ~$past(hst_wdata_i));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-to-clear misbehaved");

  property p_int;
    (flags_q & event_enable_i) != 32'h0000_0000 |=> int_o;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not raised");

  property p_pseudo;
    pseudo_tick && !bus_reset_i |=> flags_q[uev_pkg::PSEUDO_BIT];
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo frame tick lost");

  property p_frame_bytes;
    frame_rd && hst_bus8_i |=> byte_q != $past(byte_q) && hst_rdata_o[15:8] == 8'h00 &&
      hst_rdata_o[7:0] == (($past(byte_q) == uev_pkg::UEV_BYTE_LOW) ? $past(frame_q[7:0]) : $past(frame_q[15:8]));
  endproperty
  a_frame_bytes: assert property (p_frame_bytes) else $error("frame bytes out of order");

endmodule

// ===== dv/uev_host_model.sv
// Host processor model that drives the parallel register port of the event block
`timescale 1ns/1ps
module uev_host_model (
  input wire logic clk_sys_i,
  output logic [7:0] hst_addr_o,
  output logic [15:0] hst_wdata_o,
  output logic hst_wr_o,
  output logic hst_rd_o,
  output logic hst_bus8_o,
  input wire logic [15:0] hst_rdata_i,
  input wire logic hst_rvalid_i
);
  initial begin
    hst_addr_o = 8'h00;
    hst_wdata_o = 16'h0000;
    hst_wr_o = 1'b0;
    hst_rd_o = 1'b0;
    hst_bus8_o = 1'b0;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // Released lines are inverted so a stale value can never pass for a live one
  task automatic idle();
    hst_addr_o <= ~hst_addr_o;
    hst_wdata_o <= ~hst_wdata_o;
  endtask

  // A one written clears its flag, a zero leaves it alone
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    hst_addr_o <= a;
    hst_wdata_o <= d;
    hst_bus8_o <= 1'b0;
    hst_wr_o <= 1'b1;
    @(negedge clk_sys_i);
    hst_wr_o <= 1'b0;
    idle();
    // Flags move on the write edge itself; the interrupt line follows one edge later
    @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic b8, output logic [15:0] d, output logic ok);
    @(negedge clk_sys_i);
    hst_addr_o <= a;
    hst_bus8_o <= b8;
    hst_rd_o <= 1'b1;
    @(negedge clk_sys_i);
    ok = hst_rvalid_i;
    d = hst_rdata_i;
    hst_rd_o <= 1'b0;
    idle();
  endtask

  // Source found by masking the flags with the enables
  task automatic read_events(input logic [31:0] en, output logic [31:0] v, output logic ok);
    logic [15:0] lo;
    logic [15:0] hi;
    logic k1;
    logic k2;
    rd(8'h18, 1'b0, lo, k1);
    rd(8'h1a, 1'b0, hi, k2);
    v = {hi, lo} & en;
    ok = k1 & k2;
  endtask
endmodule

// ===== dv/tb_usb_event_status_and_id.sv
// Self-checking bench for the event flag, identity and frame number block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_usb_event_status_and_id;
  localparam logic [15:0] ID_VAL = 16'h3c96; // Arbitrary value
  localparam logic [7:0] VER_VAL = 8'h07; // Arbitrary value
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] hst_addr;
  logic [15:0] hst_wdata;
  logic hst_wr;
  logic hst_rd;
  logic hst_bus8;
  logic [15:0] hst_rdata;
  logic hst_rvalid;
  logic [31:0] event_enable = 32'h0;
  logic int_o;
  logic [6:0] ep_in = 7'h00;
  logic [6:0] ep_out = 7'h00;
  logic ep0_in = 1'b0;
  logic ep0_out = 1'b0;
  logic setup = 1'b0;
  logic vbus = 1'b0;
  logic [15:0] dma_reason = 16'h0000;
  logic high_speed = 1'b0;
  logic suspended = 1'b0;
  logic sof = 1'b0;
  logic [10:0] frame = 11'h000;
  logic [2:0] micro = 3'h0;
  logic bus_reset = 1'b0;
  logic otg_en = 1'b0;
  logic se0 = 1'b0;
  logic [31:0] flags;
  logic [15:0] frame_reg;
  logic [15:0] d;
  logic [31:0] v;
  logic ok;
  int errors = 0;
  int checks_done = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  uev_event_status #(.PSEUDO_FS_CYC(20), .PSEUDO_HS_CYC(8), .SE0_OTG_CYC(10), .CHIP_IDENTIFIER(ID_VAL),
    .HW_VERSION(VER_VAL)) u_uev_event_status (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .hst_addr_i(hst_addr), .hst_wdata_i(hst_wdata), .hst_wr_i(hst_wr), .hst_rd_i(hst_rd),
    .hst_bus8_i(hst_bus8), .hst_rdata_o(hst_rdata), .hst_rvalid_o(hst_rvalid), .event_enable_i(event_enable),
    .int_o(int_o), .endpoint_in_buffer_evt_i(ep_in), .endpoint_out_buffer_evt_i(ep_out), .ep0_in_evt_i(ep0_in),
    .ep0_out_evt_i(ep0_out), .setup_evt_i(setup), .vbus_pin_i(vbus), .dma_reason_i(dma_reason),
    .high_speed_i(high_speed), .suspended_i(suspended), .sof_evt_i(sof), .frame_index_i(frame),
    .microframe_index_i(micro), .bus_reset_i(bus_reset), .otg_en_i(otg_en), .se0_i(se0),
    .event_flags_o(flags), .received_frame_number_o(frame_reg));

  uev_host_model u_uev_host_model (.clk_sys_i(clk_sys_i), .hst_addr_o(hst_addr), .hst_wdata_o(hst_wdata),
    .hst_wr_o(hst_wr), .hst_rd_o(hst_rd), .hst_bus8_o(hst_bus8), .hst_rdata_i(hst_rdata),
    .hst_rvalid_i(hst_rvalid));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Index 32 stands for the interrupt line
  task automatic wait_flag(input int idx, input logic val);
    int n;
    n = 0;
    while (((idx == 32) ? int_o : flags[idx]) !== val && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK(((idx == 32) ? int_o : flags[idx]), val)
    if (n >= 40) begin
      report_and_stop();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic b8, input logic [15:0] e);
    u_uev_host_model.rd(a, b8, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask

  task automatic clr_all();
    u_uev_host_model.wr(8'h18, 16'hffff);
    u_uev_host_model.wr(8'h1a, 16'hffff);
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(1);
    rchk(8'h70, 1'b0, {ID_VAL[7:0], VER_VAL});
    rchk(8'h72, 1'b0, {8'h00, ID_VAL[15:8]});
    u_uev_host_model.wr(8'h70, 16'h0000);
    rchk(8'h70, 1'b0, {ID_VAL[7:0], VER_VAL});
    rchk(8'h40, 1'b0, 16'h0000);
    tdone("identity");
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_sys_i) ep_in[i] <= 1'b1;
      @(negedge clk_sys_i) ep_in <= 7'h00;
      wait_flag(13 + 2 * i, 1'b1);
      @(negedge clk_sys_i) ep_out[i] <= 1'b1;
      @(negedge clk_sys_i) ep_out <= 7'h00;
      wait_flag(12 + 2 * i, 1'b1);
    end
    u_uev_host_model.wr(8'h1a, 16'h0000);
    `CHK(flags[25:12], 14'h3fff)
    u_uev_host_model.wr(8'h1a, 16'h0200);
    `CHK(flags[25:12], 14'h1fff)
    @(negedge clk_sys_i) ep0_in <= 1'b1;
    @(negedge clk_sys_i) ep0_in <= 1'b0;
    wait_flag(11, 1'b1);
    @(negedge clk_sys_i) ep0_out <= 1'b1;
    @(negedge clk_sys_i) ep0_out <= 1'b0;
    wait_flag(10, 1'b1);
    event_enable <= 32'h0000_0100;
    @(negedge clk_sys_i) setup <= 1'b1;
    @(negedge clk_sys_i) setup <= 1'b0;
    wait_flag(8, 1'b1);
    wait_flag(32, 1'b1);
    u_uev_host_model.read_events(event_enable, v, ok);
    `CHK(v, 32'h0000_0100)
    u_uev_host_model.wr(8'h18, 16'h0100);
    wait_flag(32, 1'b0);
    `CHK(flags[9], 1'b0)
    tdone("buffers");
    vbus <= 1'b1;
    wait_flag(7, 1'b1);
    dma_reason <= 16'h0010;
    wait_flag(6, 1'b1);
    // Source cleared first, else its change would raise the flag again
    dma_reason <= 16'h0000;
    cyc(3);
    u_uev_host_model.wr(8'h18, 16'h0040);
    `CHK(flags[6], 1'b0)
    suspended <= 1'b1;
    wait_flag(3, 1'b1);
    high_speed <= 1'b1;
    cyc(5);
    `CHK(flags[5], 1'b0)
    high_speed <= 1'b0;
    suspended <= 1'b0;
    wait_flag(4, 1'b1);
    cyc(2);
    high_speed <= 1'b1;
    wait_flag(5, 1'b1);
    u_uev_host_model.wr(8'h18, 16'h0004);
    wait_flag(2, 1'b1);
    high_speed <= 1'b0;
    tdone("bus states");
    frame <= 11'h5a3;
    micro <= 3'h6;
    sof <= 1'b1;
    @(negedge clk_sys_i) sof <= 1'b0;
    wait_flag(1, 1'b1);
    `CHK(frame_reg, 16'h35a3)
    rchk(8'h74, 1'b0, 16'h35a3);
    rchk(8'h74, 1'b1, 16'h00a3);
    rchk(8'h74, 1'b1, 16'h0035);
    tdone("frame");
    @(negedge clk_sys_i) bus_reset <= 1'b1;
    @(negedge clk_sys_i) bus_reset <= 1'b0;
    wait_flag(0, 1'b1);
    `CHK(flags & 32'hffff_fffb, 32'h0000_0001)
    clr_all();
    otg_en <= 1'b1;
    @(negedge clk_sys_i) setup <= 1'b1;
    @(negedge clk_sys_i) setup <= 1'b0;
    wait_flag(8, 1'b1);
    @(negedge clk_sys_i) bus_reset <= 1'b1;
    @(negedge clk_sys_i) bus_reset <= 1'b0;
    wait_flag(8, 1'b0);
    cyc(2);
    `CHK(flags[0], 1'b0)
    se0 <= 1'b1;
    cyc(5);
    `CHK(flags[0], 1'b0)
    wait_flag(0, 1'b1);
    se0 <= 1'b0;
    otg_en <= 1'b0;
    tdone("bus reset");
    sys_rst_i <= 1'b1;
    cyc(2);
    `CHK(flags, 32'h0000_0000)
    sys_rst_i <= 1'b0;
    cyc(2);
    tdone("chip reset");
    report_and_stop();
  end
endmodule
